// file: bench/nvm_regs_asserts.sv
// port-level assertions for the nvm front-end register bank
// assumes binding onto the top module; ahb hready_i fed back from hreadyout_o
`timescale 1ns/1ps
module nvm_regs_asserts
    import nvm_regs_pkg::*;
(
    input wire logic        clk_sys_i,               // clock
    input wire logic        nrst_i,                  // reset, low
    input wire logic        hsel_i,                  // select
    input wire logic [31:0] haddr_i,                 // address
    input wire logic [1:0]  htrans_i,                // transfer
    input wire logic        hwrite_i,                // write
    input wire logic [31:0] hwdata_i,                // write data
    input wire logic        hready_i,                // bus ready
    input wire logic        sec_load_i,              // byte fetched
    input wire logic [7:0]  sec_byte_i,              // fetched byte
    input wire logic        backdoor_ok_i,           // key accepted
    input wire logic        op_done_i,               // op finished
    input wire logic [17:0] sec_fetch_addr_o,        // fetch address
    input wire logic        sec_fetch_req_o,         // fetch request
    input wire logic [5:0]  timing_divisor_o,        // divisor
    input wire logic        backdoor_unlock_allow_o, // key allowed
    input wire logic        part_secured_o,          // secured
    input wire logic        command_complete_flag_o  // idle
);
    ////////////////////////////////////////////////////////////////
    logic        dp_wr;
    logic        lck;
    logic [15:0] dp_a;
    wire         tk = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    wire         dw = dp_wr && dp_a == IDX_TIMING_DIVIDER;
    // lock mirror: taken from the data phase, only reset clears it
    always_ff @(posedge clk_sys_i or negedge nrst_i)
        if (!nrst_i)
            dp_wr <= 1'b0;
        else
            dp_wr <= tk;
    always_ff @(posedge clk_sys_i or negedge nrst_i)
        if (!nrst_i)
            lck <= 1'b0;
        else
            lck <= lck | (dw & hwdata_i[6]);
    always_ff @(posedge clk_sys_i)
        dp_a <= haddr_i[17:2];
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    fetch_addr_a: assert property (sec_fetch_req_o |-> sec_fetch_addr_o == SECURITY_BYTE_ADDR)
        else $error("fetch address wrong");
    allow_code_a: assert property (sec_load_i && sec_fetch_req_o |->
        ##3 backdoor_unlock_allow_o == (($past(sec_byte_i, 3) & 8'hc0) == 8'h80)) else $error("key code wrong");
    secured_code_a: assert property (sec_load_i && sec_fetch_req_o |->
        ##3 part_secured_o == (($past(sec_byte_i, 3) & 8'h03) != 8'h02)) else $error("state code wrong");
    backdoor_force_a: assert property (backdoor_ok_i && backdoor_unlock_allow_o |-> ##3 !part_secured_o)
        else $error("unlock not forced");
    done_sets_a: assert property (op_done_i |-> ##[1:3] command_complete_flag_o)
        else $error("complete flag not set");
    launch_clear_a: assert property (dp_wr && dp_a == IDX_CONTROL && hwdata_i[0] |->
        ##2 !command_complete_flag_o) else $error("launch did not clear flag");
    div_write_a: assert property (dw && !lck |->
        ##2 {26'h0, timing_divisor_o} == ($past(hwdata_i, 2) & 32'h3f)) else $error("divisor not loaded");
    div_locked_a: assert property (dw && lck |-> ##2 $stable(timing_divisor_o))
        else $error("locked divisor changed");
    cover property (dw && lck);
    cover property (backdoor_ok_i && backdoor_unlock_allow_o);
    cover property (op_done_i);
endmodule : nvm_regs_asserts

// file: bench/tb_top.sv
// self-checking bench for the nvm front-end register bank
// assumes zero-wait ahb-lite slave; bench is the only master
`timescale 1ns/1ps
module tb_top
    import nvm_regs_pkg::*;
;
    logic        clk_sys_i = 1'b0, nrst_i = 1'b0, hsel_i = 1'b1, hwrite_i = 1'b0;
    logic        sec_load_i = 1'b0, backdoor_ok_i = 1'b0, op_done_i = 1'b0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, q;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = HSIZE_WORD;
    logic [7:0]  sec_byte_i = 8'h00, nvm_configuration_o;
    logic [17:0] sec_fetch_addr_o;
    logic [5:0]  timing_divisor_o;
    logic        hready_i, hreadyout_o, hresp_o, sec_fetch_req_o, backdoor_unlock_allow_o;
    logic        part_secured_o, command_complete_flag_o;
    int          num_errors = 0, checks = 0;
    assign hready_i = hreadyout_o;
    nvm_timing_security_index_regs u_nvm_timing_security_index_regs (.*);
    initial forever #5 clk_sys_i = ~clk_sys_i;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
        @(posedge clk_sys_i);
        htrans_i <= HTRANS_NONSEQ;
        hwrite_i <= w;
        haddr_i <= {14'h0, idx, 2'h0};
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= {24'h0, d};
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
    endtask : bus
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk(q, {24'h0, e});
    endtask : rd
    // outputs trail the registers by a cycle; sample clear of the edge
    task automatic settle;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask : settle
    task automatic rst;
        nrst_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        settle();
    endtask : rst
    task automatic ld(input logic [7:0] b);
        @(posedge clk_sys_i);
        sec_load_i <= 1'b1;
        sec_byte_i <= b;
        @(posedge clk_sys_i);
        sec_load_i <= 1'b0;
        sec_byte_i <= ~b;
        settle();
    endtask : ld
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rst();
        chk(sec_fetch_req_o, 1'b1);
        chk(sec_fetch_addr_o, SECURITY_BYTE_ADDR);
        chk(part_secured_o, 1'b1);
        chk(hresp_o, 1'b0);
        chk(hreadyout_o, 1'b1);
        rd(IDX_TIMING_DIVIDER, 8'h00);
        rd(IDX_LOCKOUT_STATE, 8'h00);
        rd(IDX_CONFIGURATION, 8'h00);
    endtask : t_reset
    task automatic t_codes;
        for (int i = 0; i < 4; i++)
        begin
            rst();
            ld(8'(i * 65));
            chk(backdoor_unlock_allow_o, i == 2);
            chk(part_secured_o, i != 2);
            chk(sec_fetch_req_o, 1'b0);
            wr(IDX_LOCKOUT_STATE, 8'h3c);
            rd(IDX_LOCKOUT_STATE, 8'(i * 65));
            // a later flash delivery must not reload the byte outside reset
            ld(8'h82);
            rd(IDX_LOCKOUT_STATE, 8'(i * 65));
        end
    endtask : t_codes
    task automatic t_backdoor(input logic [7:0] b, input logic e);
        rst();
        ld(b);
        @(posedge clk_sys_i);
        backdoor_ok_i <= 1'b1;
        @(posedge clk_sys_i);
        backdoor_ok_i <= 1'b0;
        settle();
        chk(part_secured_o, e);
    endtask : t_backdoor
    task automatic t_div;
        // command flag is high here, so divider writes are legal; small divisors only exercise the field
        wr(IDX_TIMING_DIVIDER, 8'h05);
        rd(IDX_TIMING_DIVIDER, 8'h85);
        wr(IDX_TIMING_DIVIDER, 8'h4a);
        wr(IDX_TIMING_DIVIDER, 8'h03);
        rd(IDX_TIMING_DIVIDER, 8'hca);
        settle();
        chk(timing_divisor_o, 6'h0a);
    endtask : t_div
    task automatic t_index;
        wr(IDX_COMMAND_INDEX, 8'hff);
        rd(IDX_COMMAND_INDEX, 8'h07);
        for (int i = 2; i < 4; i++)
        begin
            wr(IDX_COMMAND_INDEX, 8'(i));
            wr(IDX_COMMAND_DATA_HI, 8'(i * 17));
            wr(IDX_COMMAND_DATA_LO, 8'(i * 3));
        end
        wr(IDX_COMMAND_INDEX, 8'h02);
        rd(IDX_COMMAND_DATA_HI, 8'h22);
        rd(IDX_COMMAND_DATA_LO, 8'h06);
    endtask : t_index
    task automatic t_cfg_cmd;
        wr(IDX_CONFIGURATION, 8'hff);
        rd(IDX_CONFIGURATION, 8'h93);
        rd(16'h3031, 8'h00);
        wr(IDX_CONTROL, 8'h01);
        settle();
        chk(command_complete_flag_o, 1'b0);
        @(posedge clk_sys_i);
        op_done_i <= 1'b1;
        @(posedge clk_sys_i);
        op_done_i <= 1'b0;
        settle();
        chk(command_complete_flag_o, 1'b1);
        chk(nvm_configuration_o, 8'h93);
    endtask : t_cfg_cmd
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        num_errors++;
        stop_test();
    end
    initial
    begin
        t_reset();
        t_codes();
        t_backdoor(8'h81, 1'b0);
        t_backdoor(8'h41, 1'b1);
        t_div();
        t_index();
        t_cfg_cmd();
        stop_test();
    end
endmodule : tb_top
bind nvm_timing_security_index_regs nvm_regs_asserts u_nvm_regs_asserts (.*);

// file: rtl/command_word_array.sv
// command object array: indexed 16-bit words, byte-writable high and low halves
// assumes index and strobes come from the register bank on the same clock
`timescale 1ns/1ps
module command_word_array
    import nvm_regs_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int IW    = 3
)(
    input  wire logic          clk_sys_i,   // system clock
    input  wire logic          nrst_i,      // async reset, active low
    input  wire logic [IW-1:0] index_i,     // selected word
    input  wire logic          wr_hi_i,     // write high byte
    input  wire logic          wr_lo_i,     // write low byte
    input  wire logic [7:0]    wdata_i,     // write byte
    output logic      [15:0]   word_o       // selected word
);
    logic [15:0] words [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_word
            wire sel = (index_i == IW'(g));
            always_ff @(posedge clk_sys_i or negedge nrst_i)
            begin
                if (!nrst_i)
                    words[g] <= 16'h0000;
                else if (sel && wr_hi_i)
                    words[g][15:8] <= wdata_i;
                else if (sel && wr_lo_i)
                    words[g][7:0] <= wdata_i;
            end
        end
    endgenerate

    assign word_o = words[index_i];
endmodule : command_word_array

// file: rtl/nvm_regs_pkg.sv
// constants shared by the nvm front-end register bank
// assumes a byte-addressed ahb-lite map, one 8-bit register per aligned word
package nvm_regs_pkg;
    // printed offsets are not all multiples of four: they are indices, byte address = 4 * index
    localparam logic [15:0] IDX_TIMING_DIVIDER  = 16'h3020;
    localparam logic [15:0] IDX_LOCKOUT_STATE   = 16'h3021;
    localparam logic [15:0] IDX_COMMAND_INDEX   = 16'h3022;
    localparam logic [15:0] IDX_CONFIGURATION   = 16'h3024;
    localparam logic [15:0] IDX_COMMAND_DATA_HI = 16'h302a;
    localparam logic [15:0] IDX_COMMAND_DATA_LO = 16'h302b;
    localparam logic [15:0] IDX_CONTROL         = 16'h3030;
    localparam logic [17:0] SECURITY_BYTE_ADDR  = 18'h0ff7f;

    localparam int DIV_LOADED_BIT = 7;
    localparam int DIV_LOCK_BIT   = 6;
    localparam int CFG_CCIE_BIT   = 7;
    localparam int CFG_IGNSF_BIT  = 4;
    localparam int CFG_FDFD_BIT   = 1;
    localparam int CFG_FSFD_BIT   = 0;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h93;

    localparam logic [7:0] TIMING_DIVIDER_RESET = 8'h00;
    localparam logic [7:0] COMMAND_INDEX_RESET  = 8'h00;
    localparam logic [7:0] CONFIGURATION_RESET  = 8'h00;
    localparam logic [7:0] LOCKOUT_STATE_RESET  = 8'h00;
    localparam logic [1:0] CODE_ENABLED         = 2'h2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage : nvm_regs_pkg

// file: rtl/nvm_timing_security_index_regs.sv
// front-end register bank of the flash/eeprom controller on an ahb-lite slave port
// assumes one master, single word transfers, and a sequencer that reports done
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
module nvm_timing_security_index_regs
    import nvm_regs_pkg::*;
#(
    parameter int CMD_DEPTH = 8
)(
    input  wire logic        clk_sys_i,          // system clock, 100 mhz
    input  wire logic        nrst_i,             // async reset, active low
    input  wire logic        hsel_i,             // ahb slave select
    input  wire logic [31:0] haddr_i,            // ahb address
    input  wire logic [1:0]  htrans_i,           // ahb transfer type
    input  wire logic        hwrite_i,           // ahb write
    input  wire logic [2:0]  hsize_i,            // ahb size
    input  wire logic [31:0] hwdata_i,           // ahb write data
    input  wire logic        hready_i,           // ahb bus ready
    output logic      [31:0] hrdata_o,           // ahb read data
    output logic             hreadyout_o,        // ahb slave ready
    output logic             hresp_o,            // ahb response, always okay
    input  wire logic        sec_load_i,         // pulse: security byte fetch done
    input  wire logic [7:0]  sec_byte_i,         // byte read from flash
    input  wire logic        backdoor_ok_i,      // pulse: backdoor key accepted
    input  wire logic        op_done_i,          // pulse: flash operation finished
    output logic      [17:0] sec_fetch_addr_o,   // address to fetch security byte
    output logic             sec_fetch_req_o,    // level: fetch request after reset
    output logic      [5:0]  timing_divisor_o,   // divisor to the timer
    output logic             backdoor_unlock_allow_o, // backdoor key permitted
    output logic             part_secured_o,     // security state says secured
    output logic      [7:0]  nvm_configuration_o,// configuration to sequencer
    output logic             command_complete_flag_o // controller idle
);
    localparam int IW = $clog2(CMD_DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // ahb address phase capture
    logic        ph_wr;
    logic        ph_rd;
    logic [15:0] ph_idx;
    wire         take     = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == 2'h3);
    wire  [15:0] addr_idx = haddr_i[17:2];

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ph_wr  <= 1'b0;
            ph_rd  <= 1'b0;
            ph_idx <= 16'h0000;
        end
        else
        begin
            ph_wr  <= take && hwrite_i;
            ph_rd  <= take && !hwrite_i;
            ph_idx <= addr_idx;
        end
    end

    wire [7:0] wbyte     = hwdata_i[7:0];
    wire       wr_div    = ph_wr && ph_idx == IDX_TIMING_DIVIDER;
    wire       wr_index  = ph_wr && ph_idx == IDX_COMMAND_INDEX;
    wire       wr_cfg    = ph_wr && ph_idx == IDX_CONFIGURATION;
    wire       wr_hi     = ph_wr && ph_idx == IDX_COMMAND_DATA_HI;
    wire       wr_lo     = ph_wr && ph_idx == IDX_COMMAND_DATA_LO;
    wire       wr_ctl    = ph_wr && ph_idx == IDX_CONTROL;

    ////////////////////////////////////////////////////////////////////////////
    // timing divider
    logic       div_loaded;
    logic       div_lock;
    logic [5:0] divisor;

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            div_loaded <= TIMING_DIVIDER_RESET[DIV_LOADED_BIT];
            div_lock   <= TIMING_DIVIDER_RESET[DIV_LOCK_BIT];
            divisor    <= TIMING_DIVIDER_RESET[5:0];
        end
        else if (wr_div)
        begin
            div_loaded <= 1'b1;
            div_lock   <= div_lock | wbyte[DIV_LOCK_BIT];
            if (!div_lock)
                divisor <= wbyte[5:0];
        end
    end

    wire [7:0] div_rd = {div_loaded, div_lock, divisor};

    ////////////////////////////////////////////////////////////////////////////
    // security byte, fetched once after reset release
    logic [7:0] sec_reg;
    logic       fetch_pend;

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sec_reg    <= LOCKOUT_STATE_RESET;
            fetch_pend <= 1'b1;
        end
        else
        begin
            if (fetch_pend && sec_load_i)
            begin
                sec_reg    <= sec_byte_i;
                fetch_pend <= 1'b0;
            end
            if (backdoor_ok_i && sec_reg[7:6] == CODE_ENABLED)
                sec_reg[1:0] <= CODE_ENABLED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command index, configuration, command complete
    logic [IW-1:0] cmd_index;
    logic [7:0]    cfg;
    logic          cc_flag;
    logic [15:0]   cmd_word;

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cmd_index <= COMMAND_INDEX_RESET[IW-1:0];
            cfg       <= CONFIGURATION_RESET;
            cc_flag   <= 1'b1;
        end
        else
        begin
            if (wr_index)
                cmd_index <= wbyte[IW-1:0];
            if (wr_cfg)
                cfg <= wbyte & CFG_WRITE_MASK;
            // launch clears, completion sets; completion wins the tie
            if (op_done_i)
                cc_flag <= 1'b1;
            else if (wr_ctl && wbyte[0])
                cc_flag <= 1'b0;
        end
    end

    command_word_array #(
        .DEPTH (CMD_DEPTH),
        .IW    (IW)
    ) u_cmd (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .index_i   (cmd_index),
        .wr_hi_i   (wr_hi),
        .wr_lo_i   (wr_lo),
        .wdata_i   (wbyte),
        .word_o    (cmd_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read mux; writes to the security register fall through with no effect
    wire [7:0] index_rd = {{(8-IW){1'b0}}, cmd_index};
    wire [7:0] rd_byte =
        (addr_idx == IDX_TIMING_DIVIDER)  ? div_rd   :
        (addr_idx == IDX_LOCKOUT_STATE)   ? sec_reg  :
        (addr_idx == IDX_COMMAND_INDEX)   ? index_rd :
        (addr_idx == IDX_CONFIGURATION)   ? cfg      :
        (addr_idx == IDX_COMMAND_DATA_HI) ? cmd_word[15:8] :
        (addr_idx == IDX_COMMAND_DATA_LO) ? cmd_word[7:0]  :
        (addr_idx == IDX_CONTROL)         ? {7'h00, cc_flag} : 8'h00;

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            hrdata_o <= 32'h0000_0000;
        else if (take && !hwrite_i)
            hrdata_o <= {24'h000000, rd_byte};
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            hreadyout_o             <= 1'b1;
            hresp_o                 <= 1'b0;
            sec_fetch_addr_o        <= SECURITY_BYTE_ADDR;
            sec_fetch_req_o         <= 1'b0;
            timing_divisor_o        <= TIMING_DIVIDER_RESET[5:0];
            backdoor_unlock_allow_o <= 1'b0;
            part_secured_o          <= 1'b1;
            nvm_configuration_o     <= CONFIGURATION_RESET;
            command_complete_flag_o <= 1'b1;
        end
        else
        begin
            hreadyout_o             <= 1'b1;
            hresp_o                 <= 1'b0;
            sec_fetch_addr_o        <= SECURITY_BYTE_ADDR;
            sec_fetch_req_o         <= fetch_pend && !sec_load_i;
            timing_divisor_o        <= divisor;
            backdoor_unlock_allow_o <= (sec_reg[7:6] == CODE_ENABLED);
            part_secured_o          <= (sec_reg[1:0] != CODE_ENABLED);
            nvm_configuration_o     <= cfg;
            command_complete_flag_o <= cc_flag;
        end
    end
endmodule : nvm_timing_security_index_regs
